// File: sbiops_pin_model.sv
// Far-side model: external drivers on the port A and port C lines.
// Assumes the bench sets the outside levels just after rising clock edges.
`timescale 1ns/1ps
module sbiops_pin_model (
   input wire logic [sbiops_pkg::PORT_W-1:0] i_pa_out,
   input wire logic [sbiops_pkg::PORT_W-1:0] i_pa_oe,
   input wire logic [sbiops_pkg::PORT_W-1:0] i_ext_a,
   input wire logic [sbiops_pkg::PORT_W-1:0] i_ext_c,
   output logic [sbiops_pkg::PORT_W-1:0] o_pa_in,
   output logic [sbiops_pkg::PORT_W-1:0] o_pc_in
);
   import sbiops_pkg::*;
   // ==========================================================
   // Wire levels
   // Port wins where it drives; outside level shows only on released lines
   assign o_pa_in = (i_pa_oe & i_pa_out) | (~i_pa_oe & i_ext_a);
   assign o_pc_in = i_ext_c;
endmodule

// File: sbiops_pkg.sv
// Package for the six-bit I/O port with peripheral pin steering.
// Assumes a 32-bit APB slave reaching byte registers in the low bits of aligned words.
package sbiops_pkg;

   // ==========================================================
   // Widths
   localparam int PORT_W = 6;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] PIN_LEVEL_OFS = 8'h00;
   localparam logic [7:0] PIN_DIR_OFS = 8'h04;
   localparam logic [7:0] OUT_LATCH_OFS = 8'h08;
   localparam logic [7:0] ANALOG_SEL_OFS = 8'h0c;
   localparam logic [7:0] PIN_STEER_OFS = 8'h10;
   localparam logic [7:0] PIN_MODIFY_OFS = 8'h14;

   // ==========================================================
   // Implemented bits, reset values
   localparam logic [5:0] DIR_MASK = 6'h37;
   localparam logic [5:0] DIR_FORCED = 6'h08;
   localparam logic [5:0] LATCH_MASK = 6'h37;
   localparam logic [5:0] ANALOG_MASK = 6'h17;
   localparam logic [7:0] STEER_MASK = 8'h3b;
   localparam logic [5:0] DIR_RESET = 6'h37;
   localparam logic [5:0] LATCH_RESET = 6'h00;
   localparam logic [5:0] ANALOG_RESET = 6'h17;
   localparam logic [7:0] STEER_RESET = 8'h00;

   // ==========================================================
   // Steering bit positions
   localparam int OSC_OUT_STEER_BIT = 0;
   localparam int LOGIC_CELL_STEER_BIT = 1;
   localparam int TIMER_GATE_STEER_BIT = 3;
   localparam int SLAVE_SELECT_STEER_BIT = 4;
   localparam int SERIAL_OUT_STEER_BIT = 5;

   // ==========================================================
   // Pin positions, and the bit where the modify value field starts in write data
   localparam int LINE_ONE = 1;
   localparam int LINE_TWO = 2;
   localparam int LINE_THREE = 3;
   localparam int LINE_FOUR = 4;
   localparam int LINE_FIVE = 5;
   localparam int MODIFY_VALUE_POS = 8;

endpackage

// File: sbiops_tb_top.sv
// Self-checking bench for the six-bit port: registers, pins and steering.
// Assumes the pin model stands for everything outside the port.
`timescale 1ns/1ps
module sbiops_tb_top;
   import sbiops_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [PORT_W-1:0] pa_in, pa_out, pa_oe, pc_in, pc_out, pc_ovr, ext_a, ext_c;
   logic ser, ser_en, lc, lc_en, osc, osc_en, ss_n, tgate;
   int bad_count, checked;

   sbiops_top dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'h1),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PA_IN(pa_in),
      .O_PA_OUT(pa_out), .O_PA_OE(pa_oe), .I_PC_IN(pc_in), .O_PC_OUT(pc_out),
      .O_PC_OVR(pc_ovr), .I_SERIAL_OUT(ser), .I_SERIAL_OUT_EN(ser_en),
      .I_LOGIC_CELL_OUT(lc), .I_LOGIC_CELL_EN(lc_en), .I_OSC_OUT(osc),
      .I_OSC_OUT_EN(osc_en), .O_SLAVE_SELECT_N(ss_n), .O_TIMER_GATE(tgate));

   sbiops_pin_model model (.i_pa_out(pa_out), .i_pa_oe(pa_oe), .i_ext_a(ext_a),
      .i_ext_c(ext_c), .o_pa_in(pa_in), .o_pc_in(pc_in));

   // ==========================================================
   // Bench plumbing
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Request held until pready is seen high; no latency assumed
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp);
   endtask

   // One edge for registered pin outputs, then let its updates land
   task automatic settle;
      @(posedge clk);
      #1;
   endtask

   task automatic pins(input logic [5:0] a, input logic [5:0] c);
      @(posedge clk);
      ext_a <= a;
      ext_c <= c;
   endtask

   task automatic per(input logic [5:0] v);
      @(posedge clk);
      {osc_en, osc, lc_en, lc, ser_en, ser} <= v;
   endtask

   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      logic [31:0] r;
      logic e;
      settle;
      check({26'h0, pa_oe}, 32'h0);
      check({31'h0, ss_n}, 32'h1);
      rd(PIN_DIR_OFS, 32'h3f);
      rd(ANALOG_SEL_OFS, 32'h17);
      rd(PIN_STEER_OFS, 32'h0);
      rd(PIN_LEVEL_OFS, 32'h28);
      apb(1'b0, 8'h18, 32'h0, r, e);
      check({31'h0, e}, 32'h1);
      check(r, 32'h0);
   endtask

   task automatic t_drive;
      wr(ANALOG_SEL_OFS, 32'h0);
      wr(OUT_LATCH_OFS, 32'h3f);
      rd(OUT_LATCH_OFS, 32'h37);
      wr(PIN_DIR_OFS, 32'h0);
      #1;
      check({26'h0, pa_oe}, 32'h0);
      settle;
      check({26'h0, pa_oe}, 32'h37);
      check({26'h0, pa_out & pa_oe}, 32'h37);
      rd(PIN_DIR_OFS, 32'h08);
      pins(6'h00, 6'h3f);
      rd(PIN_LEVEL_OFS, 32'h37);
      wr(PIN_LEVEL_OFS, 32'h05);
      rd(OUT_LATCH_OFS, 32'h05);
      settle;
      check({26'h0, pa_out & pa_oe}, 32'h05);
      rd(PIN_LEVEL_OFS, 32'h05);
   endtask

   task automatic t_analog;
      wr(ANALOG_SEL_OFS, 32'h17);
      settle;
      check({26'h0, pa_out & pa_oe}, 32'h05);
      pins(6'h3f, 6'h3f);
      rd(PIN_LEVEL_OFS, 32'h08);
      wr(PIN_DIR_OFS, 32'h3f);
      settle;
      rd(PIN_LEVEL_OFS, 32'h28);
      wr(ANALOG_SEL_OFS, 32'h0);
      rd(PIN_LEVEL_OFS, 32'h3f);
   endtask

   task automatic t_modify;
      pins(6'h2a, 6'h3f);
      rd(PIN_MODIFY_OFS, 32'h0);
      wr(PIN_MODIFY_OFS, 32'h0101);
      rd(OUT_LATCH_OFS, 32'h23);
      // Analog line reads zero, so the merge clears its latch bit
      wr(ANALOG_SEL_OFS, 32'h02);
      wr(PIN_MODIFY_OFS, 32'h0001);
      rd(OUT_LATCH_OFS, 32'h20);
   endtask

   task automatic t_steer;
      wr(ANALOG_SEL_OFS, 32'h0);
      wr(OUT_LATCH_OFS, 32'h0);
      wr(PIN_DIR_OFS, 32'h0);
      pins(6'h00, 6'h00);
      per(6'h3f);
      settle;
      check({26'h0, pc_ovr}, 32'h06);
      check({26'h0, pc_out}, 32'h06);
      check({26'h0, pa_out & pa_oe}, 32'h04);
      check({30'h0, ss_n, tgate}, 32'h0);
      rd(PIN_LEVEL_OFS, 32'h04);
      wr(PIN_STEER_OFS, 32'h3f);
      settle;
      check({26'h0, pc_ovr}, 32'h20);
      check({26'h0, pa_out & pa_oe}, 32'h10);
      rd(PIN_STEER_OFS, 32'h3b);
      rd(PIN_DIR_OFS, 32'h08);
      per(6'h2f);
      settle;
      check({26'h0, pa_out & pa_oe}, 32'h00);
      per(6'h0f);
      settle;
      check({26'h0, pa_out & pa_oe}, 32'h10);
      pins(6'h08, 6'h00);
      settle;
      check({30'h0, ss_n, tgate}, 32'h3);
   endtask

   // ==========================================================
   // Clock, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_a = 6'h3f;
      ext_c = 6'h3f;
      {osc_en, osc, lc_en, lc, ser_en, ser} = 6'h00;
      bad_count = 0;
      checked = 0;
      do_reset;
      t_reset;
      t_drive;
      t_analog;
      t_modify;
      t_steer;
      // Second reset in mid-run must restore direction, analog select and steering; the output latch is not read back
      pins(6'h3f, 6'h3f);
      do_reset;
      t_reset;
      complete_run;
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      complete_run;
   end
endmodule

// File: sbiops_top.sv
// Six-bit I/O port, port A, bidirectional except input-only line three, with peripheral pin steering.
// Assumes an APB master on I_CORE_CLK; pin inputs already synchronous to the clock.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module sbiops_top (
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [sbiops_pkg::ADDR_W-1:0] I_PADDR,
   input wire logic [sbiops_pkg::DATA_W-1:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   output logic [sbiops_pkg::DATA_W-1:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // Port A pins
   input wire logic [sbiops_pkg::PORT_W-1:0] I_PA_IN,
   output logic [sbiops_pkg::PORT_W-1:0] O_PA_OUT,
   output logic [sbiops_pkg::PORT_W-1:0] O_PA_OE,
   // Port C lines reached by steering
   input wire logic [sbiops_pkg::PORT_W-1:0] I_PC_IN,
   output logic [sbiops_pkg::PORT_W-1:0] O_PC_OUT,
   output logic [sbiops_pkg::PORT_W-1:0] O_PC_OVR,
   // Peripheral outputs
   input wire logic I_SERIAL_OUT,
   input wire logic I_SERIAL_OUT_EN,
   input wire logic I_LOGIC_CELL_OUT,
   input wire logic I_LOGIC_CELL_EN,
   input wire logic I_OSC_OUT,
   input wire logic I_OSC_OUT_EN,
   // Peripheral inputs
   output logic O_SLAVE_SELECT_N,
   output logic O_TIMER_GATE
);
   import sbiops_pkg::*;

   // ==========================================================
   // Bus decode
   logic setup_ph;
   logic access_ph;
   logic addr_ok;
   logic wr_lvl;
   logic wr_dir;
   logic wr_lat;
   logic wr_ana;
   logic wr_steer;
   logic wr_mod;
   logic wr_byte;

   assign setup_ph = I_PSEL && !I_PENABLE;
   assign access_ph = I_PSEL && I_PENABLE;
   assign wr_byte = access_ph && I_PWRITE && I_PSTRB[0] && addr_ok;
   assign wr_lvl = wr_byte && (I_PADDR == PIN_LEVEL_OFS);
   assign wr_dir = wr_byte && (I_PADDR == PIN_DIR_OFS);
   assign wr_lat = wr_byte && (I_PADDR == OUT_LATCH_OFS);
   assign wr_ana = wr_byte && (I_PADDR == ANALOG_SEL_OFS);
   assign wr_steer = wr_byte && (I_PADDR == PIN_STEER_OFS);
   assign wr_mod = access_ph && I_PWRITE && (I_PADDR == PIN_MODIFY_OFS);

   always_comb begin
      case (I_PADDR)
         PIN_LEVEL_OFS, PIN_DIR_OFS, OUT_LATCH_OFS, ANALOG_SEL_OFS,
         PIN_STEER_OFS, PIN_MODIFY_OFS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Zero wait states: every access phase completes at once
   assign O_PREADY = access_ph;
   assign O_PSLVERR = access_ph && !addr_ok;

   // ==========================================================
   // Configuration registers
   logic [PORT_W-1:0] dir;
   logic [PORT_W-1:0] latch;
   logic [PORT_W-1:0] ana;
   logic [7:0] steer;
   logic [PORT_W-1:0] next_dir;
   logic [PORT_W-1:0] next_latch;
   logic [PORT_W-1:0] next_ana;
   logic [7:0] next_steer;
   logic [PORT_W-1:0] pa_dig;
   logic [PORT_W-1:0] mod_mask;
   logic [PORT_W-1:0] mod_val;

   // Digital input buffer gated off by analog select
   assign pa_dig = I_PA_IN & ~ana;
   assign mod_mask = I_PWDATA[PORT_W-1:0];
   assign mod_val = I_PWDATA[MODIFY_VALUE_POS +: PORT_W];

   always_comb begin
      next_dir = dir;
      next_latch = latch;
      next_ana = ana;
      next_steer = steer;
      if (wr_dir) begin
         // Line three stays an input whatever is written
         next_dir = (I_PWDATA[PORT_W-1:0] & DIR_MASK) | DIR_FORCED;
      end
      if (wr_lvl || wr_lat) begin
         next_latch = I_PWDATA[PORT_W-1:0] & LATCH_MASK;
      end
      if (wr_mod) begin
         // Untouched bits come from the pins, so analog pins load zero
         next_latch = ((pa_dig & ~mod_mask) | (mod_val & mod_mask)) & LATCH_MASK;
      end
      if (wr_ana) begin
         next_ana = I_PWDATA[PORT_W-1:0] & ANALOG_MASK;
      end
      if (wr_steer) begin
         // Steering leaves direction alone
         next_steer = I_PWDATA[7:0] & STEER_MASK;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         dir <= DIR_RESET | DIR_FORCED;
         latch <= LATCH_RESET;
         ana <= ANALOG_RESET;
         steer <= STEER_RESET;
      end else begin
         dir <= next_dir;
         latch <= next_latch;
         ana <= next_ana;
         steer <= next_steer;
      end
   end

   // ==========================================================
   // Read data, captured in the setup cycle
   logic [DATA_W-1:0] next_prdata;

   always_comb begin
      next_prdata = O_PRDATA;
      if (setup_ph && !I_PWRITE) begin
         case (I_PADDR)
            PIN_LEVEL_OFS: next_prdata = {26'h0, pa_dig};
            PIN_DIR_OFS: next_prdata = {26'h0, dir | DIR_FORCED};
            OUT_LATCH_OFS: next_prdata = {26'h0, latch};
            ANALOG_SEL_OFS: next_prdata = {26'h0, ana};
            PIN_STEER_OFS: next_prdata = {24'h0, steer};
            default: next_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PRDATA <= 32'h0;
      end else begin
         O_PRDATA <= next_prdata;
      end
   end

   // ==========================================================
   // Pin steering and output priority
   logic osc_on_a4;
   logic osc_on_c1;
   logic sdo_on_a4;
   logic sdo_on_c2;
   logic clc_on_a2;
   logic clc_on_c5;
   logic [PORT_W-1:0] next_pa_out;
   logic [PORT_W-1:0] next_pa_oe;
   logic [PORT_W-1:0] next_pc_out;
   logic [PORT_W-1:0] next_pc_ovr;
   logic next_ss_n;
   logic next_tgate;

   assign osc_on_a4 = I_OSC_OUT_EN && steer[OSC_OUT_STEER_BIT];
   assign osc_on_c1 = I_OSC_OUT_EN && !steer[OSC_OUT_STEER_BIT];
   assign sdo_on_a4 = I_SERIAL_OUT_EN && steer[SERIAL_OUT_STEER_BIT];
   assign sdo_on_c2 = I_SERIAL_OUT_EN && !steer[SERIAL_OUT_STEER_BIT];
   assign clc_on_a2 = I_LOGIC_CELL_EN && !steer[LOGIC_CELL_STEER_BIT];
   assign clc_on_c5 = I_LOGIC_CELL_EN && steer[LOGIC_CELL_STEER_BIT];

   always_comb begin
      // Latch by default; direction alone sets the driver, analog ignored
      next_pa_out = latch;
      next_pa_oe = ~dir & DIR_MASK;
      // Oscillator outranks serial data on line four
      if (osc_on_a4) begin
         next_pa_out[LINE_FOUR] = I_OSC_OUT;
      end else if (sdo_on_a4) begin
         next_pa_out[LINE_FOUR] = I_SERIAL_OUT;
      end
      if (clc_on_a2) begin
         next_pa_out[LINE_TWO] = I_LOGIC_CELL_OUT;
      end
      // Port C overrides, for that port's own driver logic
      next_pc_out = '0;
      next_pc_ovr = '0;
      next_pc_out[LINE_ONE] = osc_on_c1 & I_OSC_OUT;
      next_pc_ovr[LINE_ONE] = osc_on_c1;
      next_pc_out[LINE_TWO] = sdo_on_c2 & I_SERIAL_OUT;
      next_pc_ovr[LINE_TWO] = sdo_on_c2;
      next_pc_out[LINE_FIVE] = clc_on_c5 & I_LOGIC_CELL_OUT;
      next_pc_ovr[LINE_FIVE] = clc_on_c5;
      // Inputs from the selected pin only
      if (steer[SLAVE_SELECT_STEER_BIT]) begin
         next_ss_n = pa_dig[LINE_THREE];
      end else begin
         next_ss_n = I_PC_IN[LINE_THREE];
      end
      if (steer[TIMER_GATE_STEER_BIT]) begin
         next_tgate = pa_dig[LINE_THREE];
      end else begin
         next_tgate = pa_dig[LINE_FOUR];
      end
   end

   // One register stage; pins settle the edge after the write
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PA_OUT <= '0;
         O_PA_OE <= '0;
         O_PC_OUT <= '0;
         O_PC_OVR <= '0;
         O_SLAVE_SELECT_N <= 1'b1;
         O_TIMER_GATE <= 1'b0;
      end else begin
         O_PA_OUT <= next_pa_out;
         O_PA_OE <= next_pa_oe;
         O_PC_OUT <= next_pc_out;
         O_PC_OVR <= next_pc_ovr;
         O_SLAVE_SELECT_N <= next_ss_n;
         O_TIMER_GATE <= next_tgate;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_RST_N);

   input_only_line_a: assert property (!O_PA_OE[LINE_THREE])
      else $error("line three output driver enabled");

   dir_to_driver_a: assert property (
      wr_dir |-> ##2 (O_PA_OE == (~$past(I_PWDATA[5:0], 2) & DIR_MASK)))
      else $error("direction write not seen on drivers two edges later");

   dir_reads_forced_a: assert property (
      (setup_ph && !I_PWRITE && I_PADDR == PIN_DIR_OFS) |=> O_PRDATA[LINE_THREE])
      else $error("line three direction did not read one");

   latch_drives_pin_a: assert property (
      !dir[0] |=> (O_PA_OE[0] && O_PA_OUT[0] == $past(latch[0])))
      else $error("output pin does not carry latch value");

   input_no_drive_a: assert property (dir[1] |=> !O_PA_OE[1])
      else $error("input pin is driven");

   analog_still_out_a: assert property (
      (!dir[1] && ana[1]) |=> (O_PA_OE[1] && O_PA_OUT[1] == $past(latch[1])))
      else $error("analog select blocked digital output");

   analog_reads_zero_a: assert property (
      (setup_ph && !I_PWRITE && I_PADDR == PIN_LEVEL_OFS && ana[0]) |=> !O_PRDATA[0])
      else $error("analog pin read as one");

   level_read_pins_a: assert property (
      (setup_ph && !I_PWRITE && I_PADDR == PIN_LEVEL_OFS && !ana[2])
      |=> O_PRDATA[2] == $past(I_PA_IN[2]))
      else $error("level read does not follow the pin");

   level_write_latch_a: assert property (
      (wr_lvl || wr_lat) |=> latch == ($past(I_PWDATA[5:0]) & LATCH_MASK))
      else $error("level or latch write did not load latch");

   modify_write_a: assert property (
      wr_mod |=> latch == ((($past(pa_dig) & ~$past(mod_mask))
                 | ($past(mod_val) & $past(mod_mask))) & LATCH_MASK))
      else $error("read-modify-write merged wrong bits");

   steer_keeps_dir_a: assert property (wr_steer |=> $stable(dir))
      else $error("steering write altered direction");

   osc_priority_a: assert property (
      (I_OSC_OUT_EN && steer[0]) |=> O_PA_OUT[4] == $past(I_OSC_OUT))
      else $error("oscillator lost line four");

   sdo_on_c2_a: assert property (
      (I_SERIAL_OUT_EN && !steer[5])
      |=> (O_PC_OVR[2] && O_PC_OUT[2] == $past(I_SERIAL_OUT)))
      else $error("serial data out missing on line two of port C");

   clc_on_a2_a: assert property (
      (I_LOGIC_CELL_EN && !steer[1]) |=> (O_PA_OUT[2] == $past(I_LOGIC_CELL_OUT)
                                          && !O_PC_OVR[5]))
      else $error("logic cell output not on line two");

   // Override must show on port C whoever owns line four
   nco_on_c1_a: assert property (
      (I_OSC_OUT_EN && !steer[0]) |=> (O_PC_OVR[1] && (O_PA_OUT[4] == $past(latch[4])
                                       || $past(sdo_on_a4))))
      else $error("oscillator output not on line one of port C");

   ss_route_a: assert property (
      !steer[4] |=> O_SLAVE_SELECT_N == $past(I_PC_IN[3]))
      else $error("slave select not from port C line three");

   tgate_route_a: assert property (
      steer[3] |=> O_TIMER_GATE == $past(pa_dig[3]))
      else $error("timer gate not from line three");

   analog_reset_a: assert property ($rose(I_RST_N) |-> ana == ANALOG_RESET)
      else $error("analog select not all set after reset");

   dir_forced_reg_a: assert property (dir[LINE_THREE])
      else $error("line three direction bit cleared");

   oe_follows_dir_a: assert property (
      1'b1 |=> O_PA_OE == (~$past(dir) & DIR_MASK))
      else $error("driver enables do not follow direction");

   line_five_latch_a: assert property (
      1'b1 |=> O_PA_OUT[LINE_FIVE] == $past(latch[LINE_FIVE]))
      else $error("line five does not carry its latch bit");

   latch_read_a: assert property (
      (setup_ph && !I_PWRITE && I_PADDR == OUT_LATCH_OFS) |=> O_PRDATA == {26'h0, $past(latch)})
      else $error("latch read does not return stored latch");

   analog_blanks_read_a: assert property (
      (setup_ph && !I_PWRITE && I_PADDR == PIN_LEVEL_OFS)
      |=> (O_PRDATA[PORT_W-1:0] & $past(ana)) == 6'h00)
      else $error("analog line leaked into level read");

   sdo_on_a4_a: assert property (
      (sdo_on_a4 && !osc_on_a4)
      |=> (O_PA_OUT[LINE_FOUR] == $past(I_SERIAL_OUT) && !O_PC_OVR[LINE_TWO]))
      else $error("serial data out not on line four");

   ss_from_a3_a: assert property (
      steer[4] |=> O_SLAVE_SELECT_N == $past(pa_dig[LINE_THREE]))
      else $error("slave select not from line three");

   tgate_from_a4_a: assert property (
      !steer[3] |=> O_TIMER_GATE == $past(pa_dig[LINE_FOUR]))
      else $error("timer gate not from line four");

   clc_on_c5_a: assert property (
      clc_on_c5 |=> (O_PC_OVR[LINE_FIVE] && O_PC_OUT[LINE_FIVE] == $past(I_LOGIC_CELL_OUT)
                     && O_PA_OUT[LINE_TWO] == $past(latch[LINE_TWO])))
      else $error("logic cell output not on port C line five");

   osc_leaves_c1_a: assert property (
      osc_on_a4 |=> (!O_PC_OVR[LINE_ONE] && !O_PC_OUT[LINE_ONE]))
      else $error("unselected oscillator pin still overridden");

   // Lines without a steered function must never be claimed
   spare_c_idle_a: assert property (
      !(O_PC_OVR[0] || O_PC_OVR[LINE_THREE] || O_PC_OVR[LINE_FOUR]))
      else $error("unsteered port C line overridden");

endmodule
